/* src/lpf_map.svh */
`ifndef LPF_MAP_SVH
`define LPF_MAP_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define LPF_OFF_CTRL     12'h000
`define LPF_OFF_STAT     12'h004
`define LPF_OFF_CNT      12'h008

// ****************************************************************
// field positions and reset values
// ****************************************************************
`define LPF_CTRL_W       5
`define LPF_CTRL_FF_EN   0
`define LPF_CTRL_TYPE2   1
`define LPF_CTRL_GPIO_O  2
`define LPF_CTRL_GPIO_OE 3
`define LPF_CTRL_HOLD    4
`define LPF_CTRL_RST     5'h01
`define LPF_STAT_W       7
`define LPF_CNT_W        16

// ****************************************************************
// timing
// ****************************************************************
`define LPF_CLK_NS       10
`define LPF_ENTRY_NS     1000
`define LPF_ENTRY_CYC    (`LPF_ENTRY_NS / `LPF_CLK_NS)
`define LPF_ENTRY_W      8
`define LPF_FILT_NS      40
`define LPF_FILT_CYC     ((`LPF_FILT_NS + `LPF_CLK_NS - 1) / `LPF_CLK_NS)
`define LPF_FILT_W       4

`endif

/* src/lpf_pkg.sv */
package lpf_pkg;

  typedef enum logic [1:0] {st_run, st_enter, st_frozen} lpf_state_t;
  typedef logic [11:0] lpf_addr_t;
  typedef logic [31:0] lpf_word_t;

endpackage

/* src/lpf_frz_if.sv */
interface lpf_frz_if;
  logic pin_low_filt;
  logic enter_ok;
  logic frozen;
  logic entering;
  logic entry_pulse;

  modport filt
  (
    output pin_low_filt
  );
  modport seq
  (
    input  pin_low_filt,
    input  enter_ok,
    output frozen,
    output entering,
    output entry_pulse
  );
  modport top
  (
    input  pin_low_filt,
    input  frozen,
    input  entering,
    input  entry_pulse,
    output enter_ok
  );
endinterface

/* src/lpf_glitch_filt.sv */
`include "lpf_map.svh"

module lpf_glitch_filt
(
  input  wire logic i_clk,
  input  wire logic i_nrst,
  input  wire logic i_raw_low,
  lpf_frz_if.filt   f
);
  localparam logic [`LPF_FILT_W-1:0] FILT_LAST = `LPF_FILT_W'(`LPF_FILT_CYC - 1);

  logic                   level_q;
  logic [`LPF_FILT_W-1:0] cnt_q;
  wire                    differs = i_raw_low != level_q;
  wire                    settle  = differs && (cnt_q == FILT_LAST);

  // level flips only after a steady run of differing samples
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      level_q <= 1'b0;
      cnt_q   <= '0;
    end
    else
    begin
      level_q <= settle ? i_raw_low : level_q;
      cnt_q   <= (differs && !settle) ? cnt_q + `LPF_FILT_W'(1) : '0;
    end
  end

  assign f.pin_low_filt = level_q;

  a_filt_settled : assert property (@(posedge i_clk) disable iff (!i_nrst)
    $changed(level_q) |-> $past(cnt_q) == FILT_LAST && $past(i_raw_low) == level_q)
    else $error("filtered level changed before input settled");
endmodule

/* src/lpf_freeze_seq.sv */
`include "lpf_map.svh"

module lpf_freeze_seq
  import lpf_pkg::*;
(
  input  wire logic i_clk,
  input  wire logic i_nrst,
  lpf_frz_if.seq    f
);
  localparam logic [`LPF_ENTRY_W-1:0] ENTRY_LAST = `LPF_ENTRY_W'(`LPF_ENTRY_CYC - 1);

  lpf_state_t              state_q;
  lpf_state_t              state_d;
  logic [`LPF_ENTRY_W-1:0] cnt_q;
  wire                     expire = (state_q == st_enter) && f.enter_ok && (cnt_q == ENTRY_LAST);

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      st_run:    if (f.enter_ok) state_d = st_enter;
      st_enter:  if (!f.enter_ok) state_d = st_run; else if (expire) state_d = st_frozen;
      st_frozen: if (!f.pin_low_filt) state_d = st_run;
      default:   state_d = st_run;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      state_q <= st_run;
      cnt_q   <= '0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q   <= (state_q == st_enter) ? cnt_q + `LPF_ENTRY_W'(1) : '0;
    end
  end

  assign f.frozen      = state_q == st_frozen;
  assign f.entering    = state_q == st_enter;
  assign f.entry_pulse = expire;

  a_entry_time : assert property (@(posedge i_clk) disable iff (!i_nrst)
    $rose(f.frozen) |-> $past(cnt_q) == ENTRY_LAST && $past(f.entering))
    else $error("freeze entered without the full entry delay");
endmodule

/* src/lpf_ctrl.sv */
// Notes on behaviour
// - type 1: freeze 1 us after request pin goes low; resume when high
// - type 1: request pin level alone decides entry and exit
// - type 2: entry needs pin low and enable high; exit on pin high
// - frozen: registers and memories kept; resume without reload
// - frozen: pll clocks stop automatically; external clocks harmless
// - request pin passes a glitch filter before use
// - request pin level is routed into core logic
// - freeze function off: request pin works as general purpose io
// - static idle keeps memory, io and registers; clocks restart resumes
// - pll power down low stops pll clocks, device enters static idle
// - hold variant keeps io states while frozen
// - low static enable is active high and affects entry only
// - frozen: pads without pull go tristate, pulled pads keep pull
// - frozen: unheld inputs present constant high to core
`include "lpf_map.svh"

module lpf_ctrl
  import lpf_pkg::*;
(
  input  wire logic              i_clk,
  input  wire logic              i_nrst,
  input  wire logic              i_psel,
  input  wire logic              i_penable,
  input  wire logic              i_pwrite,
  input  wire lpf_pkg::lpf_addr_t i_paddr,
  input  wire lpf_pkg::lpf_word_t i_pwdata,
  output      lpf_pkg::lpf_word_t o_prdata,
  output      logic              o_pready,
  output      logic              o_pslverr,
  input  wire logic              i_freeze_request_pin_n,
  output      logic              o_freeze_request_pin_o,
  output      logic              o_freeze_request_pin_oe,
  input  wire logic              i_low_static_enable,
  input  wire logic              i_pll_power_down_n,
  output      logic              o_freeze_req_core,
  output      logic              o_frozen,
  output      logic              o_core_clk_en,
  output      logic              o_pll_clk_en,
  output      logic              o_static_idle,
  output      logic              o_io_tristate,
  output      logic              o_io_hold,
  output      logic              o_core_in_high
);
  // ****************************************************************
  // submodules
  // ****************************************************************
  lpf_frz_if f ();

  logic [`LPF_CTRL_W-1:0] ctrl_q;
  wire                    ff_en   = ctrl_q[`LPF_CTRL_FF_EN];
  wire                    type2   = ctrl_q[`LPF_CTRL_TYPE2];
  wire                    hold_en = ctrl_q[`LPF_CTRL_HOLD];

  // pin feeds the filter only when the freeze function owns it
  wire raw_low = ff_en & ~i_freeze_request_pin_n;

  lpf_glitch_filt u_filt
  (
    .i_clk     (i_clk),
    .i_nrst    (i_nrst),
    .i_raw_low (raw_low),
    .f         (f)
  );

  lpf_freeze_seq u_seq
  (
    .i_clk  (i_clk),
    .i_nrst (i_nrst),
    .f      (f)
  );

  // enable matters only for type 2 entry; exit ignores it
  assign f.enter_ok = f.pin_low_filt & (~type2 | i_low_static_enable);

  // ****************************************************************
  // apb slave
  // ****************************************************************
  logic                   pready_q;
  lpf_word_t              prdata_q;
  logic                   pslverr_q;
  logic [`LPF_CNT_W-1:0]  frz_cnt_q;
  logic [`LPF_STAT_W-1:0] stat_w;

  wire       access   = i_psel & i_penable;
  wire       answer   = access & ~pready_q;
  wire       done     = access & pready_q;
  wire       hit_ctrl = i_paddr == `LPF_OFF_CTRL;
  wire       hit_stat = i_paddr == `LPF_OFF_STAT;
  wire       hit_cnt  = i_paddr == `LPF_OFF_CNT;
  wire       addr_ok  = hit_ctrl | hit_stat | hit_cnt;
  wire       wr_ctrl  = done & i_pwrite & hit_ctrl;
  lpf_word_t rd_word;

  assign stat_w = {i_low_static_enable, f.entering, o_static_idle, o_pll_clk_en,
                   i_freeze_request_pin_n, f.pin_low_filt, f.frozen};

  assign rd_word = hit_ctrl ? {{(32 - `LPF_CTRL_W){1'b0}}, ctrl_q}
                 : hit_stat ? {{(32 - `LPF_STAT_W){1'b0}}, stat_w}
                 : hit_cnt  ? {{(32 - `LPF_CNT_W){1'b0}}, frz_cnt_q}
                 : 32'h0000_0000;

  // one wait state, then answer
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end
    else
    begin
      pready_q  <= answer;
      prdata_q  <= (answer & ~i_pwrite) ? rd_word : 32'h0000_0000;
      pslverr_q <= answer & ~addr_ok;
    end
  end

  // control word is not touched by freezing, so it survives
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      ctrl_q <= `LPF_CTRL_RST;
    else if (wr_ctrl)
      ctrl_q <= i_pwdata[`LPF_CTRL_W-1:0];
  end

  // counts freeze entries, wraps
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      frz_cnt_q <= '0;
    else if (f.entry_pulse)
      frz_cnt_q <= frz_cnt_q + `LPF_CNT_W'(1);
  end

  assign o_pready  = pready_q;
  assign o_prdata  = prdata_q;
  assign o_pslverr = pslverr_q;

  // ****************************************************************
  // clock, pad and core side controls
  // ****************************************************************
  wire pll_on    = i_pll_power_down_n;
  wire pin_oe_d  = ~ff_en & ctrl_q[`LPF_CTRL_GPIO_OE];
  wire tristate  = f.frozen & ~hold_en;

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_frozen      <= 1'b0;
      o_core_clk_en <= 1'b1;
      o_pll_clk_en  <= 1'b0;
      o_static_idle <= 1'b0;
    end
    else
    begin
      o_frozen      <= f.frozen;
      o_core_clk_en <= ~f.frozen;
      o_pll_clk_en  <= pll_on & ~f.frozen;
      o_static_idle <= ~pll_on;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_io_tristate           <= 1'b0;
      o_io_hold               <= 1'b0;
      o_core_in_high          <= 1'b0;
      o_freeze_req_core       <= 1'b0;
      o_freeze_request_pin_o  <= 1'b0;
      o_freeze_request_pin_oe <= 1'b0;
    end
    else
    begin
      o_io_tristate           <= tristate;
      o_io_hold               <= f.frozen & hold_en;
      o_core_in_high          <= tristate;
      o_freeze_req_core       <= f.pin_low_filt;
      o_freeze_request_pin_o  <= ctrl_q[`LPF_CTRL_GPIO_O];
      o_freeze_request_pin_oe <= pin_oe_d;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_nrst);

  sequence s_frozen;
    f.frozen;
  endsequence

  sequence s_release;
    !f.pin_low_filt;
  endsequence

  sequence s_idle_run;
    !f.frozen && !f.entering;
  endsequence

  property p_exit_on_release;
    s_frozen ##0 s_release |=> !f.frozen ##1 o_core_clk_en && !o_frozen;
  endproperty

  a_exit_on_pin : assert property (p_exit_on_release)
    else $error("freeze not left after request pin release");

  a_exit_no_lse : assert property (s_frozen ##0 f.pin_low_filt |=> f.frozen)
    else $error("freeze left while request still asserted");

  a_type1_entry : assert property (s_idle_run ##0 (ff_en && !type2 && f.pin_low_filt) |=> f.entering)
    else $error("type 1 entry did not start on pin alone");

  a_type2_gate : assert property (s_idle_run ##0 (type2 && !i_low_static_enable) |=> !f.entering)
    else $error("type 2 entry started without low static enable");

  a_pll_stop : assert property (f.frozen |=> !o_pll_clk_en && !o_core_clk_en)
    else $error("clocks still enabled while frozen");

  a_ctrl_kept : assert property (f.frozen && !wr_ctrl |=> $stable(ctrl_q))
    else $error("control state disturbed while frozen");

  a_idle_pll : assert property (!i_pll_power_down_n |=> o_static_idle && !o_pll_clk_en)
    else $error("pll power down did not enter static idle");

  a_gpio_owner : assert property (ff_en |=> !o_freeze_request_pin_oe)
    else $error("request pin driven while freeze function active");

  a_route_core : assert property ($rose(o_freeze_req_core) |-> $past(f.pin_low_filt) && $past(raw_low, 5))
    else $error("core request rose without filtered pin");

  a_io_hold : assert property (f.frozen && hold_en |=> o_io_hold && !o_io_tristate && !o_core_in_high)
    else $error("io hold not applied while frozen");

  a_io_tri : assert property (f.frozen && !hold_en |=> o_io_tristate && o_core_in_high)
    else $error("pads not tristated or core inputs not high while frozen");

  a_apb_wait : assert property (answer |=> o_pready ##1 !o_pready)
    else $error("apb answer not one cycle after access");
endmodule

/* sim/lpf_far_end.sv */
// ****************************************************************
// far side: outside controller and user core logic
// ****************************************************************
module lpf_far_end
(
  input  wire logic i_clk,
  output      logic o_pin_n,
  output      logic o_lse
);
  timeunit 1ns;
  timeprecision 1ps;

  // outside pushes the pin while its clocks keep running
  initial
  begin
    o_pin_n = 1'b1;
    o_lse   = 1'b0;
  end

  // pin level, changed just after an edge
  task pin(input logic lvl);
    @(posedge i_clk);
    o_pin_n <= lvl;
  endtask

  // enable raised while user clocks still run, before type 2 entry, dropped after exit
  task lse(input logic v);
    @(posedge i_clk);
    o_lse <= v;
  endtask
endmodule

/* sim/lpf_ctrl_tb.sv */
module lpf_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import lpf_pkg::*;

  logic      i_clk, i_nrst, psel, penable, pwrite, pready, pslverr, pd_n;
  lpf_addr_t paddr;
  lpf_word_t pwdata, prdata, rd;
  logic      pin_o, pin_oe, far_pin, lse, req_core, frozen, core_en, pll_en;
  logic      idle, tri_s, hold, in_high, er;
  wire       pin_n = pin_oe ? pin_o : far_pin;
  int        mismatches, n_tests, cycles;

  lpf_ctrl dut
  (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_freeze_request_pin_n(pin_n), .o_freeze_request_pin_o(pin_o), .o_freeze_request_pin_oe(pin_oe),
    .i_low_static_enable(lse), .i_pll_power_down_n(pd_n), .o_freeze_req_core(req_core),
    .o_frozen(frozen), .o_core_clk_en(core_en), .o_pll_clk_en(pll_en), .o_static_idle(idle),
    .o_io_tristate(tri_s), .o_io_hold(hold), .o_core_in_high(in_high)
  );

  lpf_far_end far
  (
    .i_clk(i_clk), .o_pin_n(far_pin), .o_lse(lse)
  );

  // ****************************************************************
  // helpers
  // ****************************************************************
  initial
  begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  always @(posedge i_clk)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      mismatches++;
      stop_test();
    end
  end

  task stop_test;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task chk(input string nm, input lpf_word_t exp, input lpf_word_t got);
    n_tests++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task apb(input logic wr, input lpf_addr_t a, input lpf_word_t d);
    @(posedge i_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge i_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge i_clk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task rd_chk(input string nm, input lpf_addr_t a, input lpf_word_t exp);
    apb(1'b0, a, 32'h0);
    chk(nm, exp, rd);
  endtask

  task cyc(input int n);
    repeat (n) @(posedge i_clk);
  endtask

  // wait bounded for a level, then judge it
  task automatic wt(input string nm, ref logic s, input logic v, input int n);
    for (int i = 0; i < n && s !== v; i++)
      @(posedge i_clk);
    chk(nm, {31'h0, v}, {31'h0, s});
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task t_regs;
    rd_chk("ctrl", 12'h000, 32'h01);
    rd_chk("stat", 12'h004, 32'h0c);
    rd_chk("cnt", 12'h008, 32'h0);
    apb(1'b1, 12'h004, 32'hff);
    rd_chk("stat_ro", 12'h004, 32'h0c);
    apb(1'b0, 12'h00c, 32'h0);
    chk("slverr", 32'h1, {31'h0, er});
  endtask

  task t_glitch;
    logic s;
    s = 1'b0;
    far.pin(1'b0);
    far.pin(1'b0);
    far.pin(1'b0);
    far.pin(1'b1);
    repeat (12)
    begin
      @(posedge i_clk);
      s = s | req_core | frozen;
    end
    chk("glitch", 32'h0, {31'h0, s});
  endtask

  task t_type1;
    far.pin(1'b0);
    cyc(8);
    chk("req_core", 32'h1, {31'h0, req_core});
    cyc(85);
    chk("early", 32'h0, {31'h0, frozen});
    wt("frozen", frozen, 1'b1, 30);
    chk("core_en", 32'h0, {31'h0, core_en});
    chk("pll_en", 32'h0, {31'h0, pll_en});
    chk("tri", 32'h1, {31'h0, tri_s});
    chk("in_high", 32'h1, {31'h0, in_high});
    chk("hold", 32'h0, {31'h0, hold});
    rd_chk("ctrl_kept", 12'h000, 32'h01);
    far.pin(1'b1);
    wt("exit", frozen, 1'b0, 10);
    rd_chk("cnt1", 12'h008, 32'h1);
  endtask

  task t_type2;
    apb(1'b1, 12'h000, 32'h03);
    far.pin(1'b0);
    cyc(150);
    chk("t2_pin_only", 32'h0, {31'h0, frozen});
    far.lse(1'b1);
    wt("t2_frozen", frozen, 1'b1, 130);
    far.pin(1'b1);
    wt("t2_exit", frozen, 1'b0, 10);
    far.lse(1'b0);
  endtask

  task t_hold;
    apb(1'b1, 12'h000, 32'h11);
    far.pin(1'b0);
    wt("h_frozen", frozen, 1'b1, 130);
    chk("h_hold", 32'h1, {31'h0, hold});
    chk("h_tri", 32'h0, {31'h0, tri_s});
    far.pin(1'b1);
    wt("h_exit", frozen, 1'b0, 10);
  endtask

  task t_gpio;
    apb(1'b1, 12'h000, 32'h00);
    far.pin(1'b0);
    cyc(150);
    chk("gpio_nofrz", 32'h0, {31'h0, frozen});
    apb(1'b1, 12'h000, 32'h0c);
    cyc(2);
    chk("gpio_oe", 32'h1, {31'h0, pin_oe});
    chk("gpio_wire", 32'h1, {31'h0, pin_n});
    far.pin(1'b1);
    apb(1'b1, 12'h000, 32'h01);
    cyc(2);
    chk("gpio_off", 32'h0, {31'h0, pin_oe});
  endtask

  task t_pll;
    @(posedge i_clk);
    pd_n <= 1'b0;
    cyc(3);
    chk("idle", 32'h1, {31'h0, idle});
    chk("pll_off", 32'h0, {31'h0, pll_en});
    rd_chk("stat_idle", 12'h004, 32'h14);
    pd_n <= 1'b1;
    cyc(3);
    chk("pll_on", 32'h1, {31'h0, pll_en});
    rd_chk("ctrl_idle", 12'h000, 32'h01);
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial
  begin
    mismatches = 0;
    n_tests = 0;
    cycles = 0;
    i_nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pd_n = 1'b1;
    cyc(20);
    i_nrst <= 1'b1;
    t_regs();
    t_glitch();
    t_type1();
    t_type2();
    t_hold();
    t_gpio();
    t_pll();
    stop_test();
  end
endmodule
